// ---- pkg/sro_pkg.sv ----
// Shared constants for the strobed four-channel register output port.
package sro_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Port geometry.
  ////////////////////////////////////////////////////////////////////////////

  // Number of output channels, each one word wide.
  localparam int NUM_CHAN = 4;
  // Width of one channel word and of the shared data lines.
  localparam int WORD_W = 16;
  // Width of the whole captured set of four words.
  localparam int SET_W = NUM_CHAN * WORD_W;
  // Depth of the buffer between the backplane capture and the field sequencer.
  localparam int FIFO_DEPTH = 4;
  // Bit position of channel one inside a captured set; channel n sits n-1 words higher.
  localparam int CHAN_ONE_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  ////////////////////////////////////////////////////////////////////////////

  // System clock rate in MHz and period in ns.
  localparam int CLK_MHZ = 125;
  localparam int CLK_NS = 8;
  // Width of each strobe pulse in microseconds.
  localparam int STROBE_US = 200;
  // Strobe width in clock cycles.
  localparam int STROBE_CYC = STROBE_US * CLK_MHZ;
  // Data set-up time ahead of a strobe, in ns, rounded up to cycles.
  localparam int SETUP_NS = 1000;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // Data hold time after a strobe, in ns, rounded up to cycles.
  localparam int HOLD_NS = 1000;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Longest time from a backplane write to the finished field update, in us.
  localparam int RESPONSE_US = 11300;
  // Longest response in cycles, rounded down.
  localparam int RESPONSE_CYC = RESPONSE_US * CLK_MHZ;
  // Width of the phase counter; holds the longest phase.
  localparam int CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Number formats.
  ////////////////////////////////////////////////////////////////////////////

  // Largest value that four decimal digits can carry.
  localparam logic [15:0] BCD_MAX = 16'h270F;
  // Largest value of one decimal digit.
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    SRO_IDLE = 4'b0001,
    SRO_SETUP = 4'b0010,
    SRO_STROBE = 4'b0100,
    SRO_HOLD = 4'b1000
  } sro_state_t;

endpackage

// ---- rtl/sro_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module sro_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Storage array, one entry per buffered word.
  logic [WIDTH-1:0] mem_q [DEPTH];
  // Read and write pointers.
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W-1:0] wr_ptr_q;
  // Number of entries held.
  logic [PTR_W:0] count_q;
  logic [PTR_W:0] count_d;

  // Handshakes that really move a word.
  wire push_w = in_valid_in && in_ready_out;
  wire pop_w = out_valid_out && out_ready_in;

  assign out_data_out = mem_q[rd_ptr_q];

  // The count moves by one on a push or a pop, and stays on both.
  always_comb begin
    count_d = count_q;
    if (push_w && !pop_w) begin
      count_d = count_q + 1'b1;
    end else if (pop_w && !push_w) begin
      count_d = count_q - 1'b1;
    end
  end

  // Pointers and flags are registered, so ready and valid are clean flops.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      if (push_w) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      in_ready_out <= (count_d != (PTR_W + 1)'(DEPTH));
      out_valid_out <= (count_d != '0);
    end
  end

  // Data entries need no reset.
  always_ff @(posedge sys_clk_in) begin
    if (push_w) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

endmodule

// ---- rtl/sro_port.sv ----
// Strobed four-channel register output port with field sequencer.
`timescale 1ns/10ps

// How it works
// - Four 16-bit channel words, one shared path.
// - Decimal mode carries four digits, 0000 to 9999.
// - Binary mode drives full unsigned range to FFFF.
// - Each channel word tied to exactly one strobe.
// - Only the strobed field device accepts data.
// - All data lines reach every device in parallel.
// - All four words captured in one write.
// - Polarity switch sets level of all strobes after reset; reset drives all high.
// - Format switch chooses decimal or binary words.
// - Mapping type plus switch gives the format.
// - Field update finishes within 11.3 ms.
// - Words writable as all 64 bits or as masked bits.
module sro_port #(
  parameter int STROBE_CYC = sro_pkg::STROBE_CYC,
  parameter int RESPONSE_CYC = sro_pkg::RESPONSE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic bus_write_in,
  input wire logic [sro_pkg::SET_W-1:0] bus_words_in,
  input wire logic [sro_pkg::SET_W-1:0] bus_bit_mask_in,
  input wire logic word_mapped_in,
  input wire logic map_bcd_in,
  input wire logic format_bcd_switch_in,
  input wire logic strobe_polarity_switch_in,
  output logic bus_ready_out,
  output logic [sro_pkg::WORD_W-1:0] data_out,
  output logic [sro_pkg::NUM_CHAN-1:0] strobe_out,
  output logic busy_out,
  output logic fmt_bcd_out,
  output logic fmt_error_out,
  output logic range_error_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  ////////////////////////////////////////////////////////////////////////////

  // Channel words as the controller last wrote them.
  logic [sro_pkg::SET_W-1:0] hold_q;
  logic [sro_pkg::SET_W-1:0] hold_d;
  // Switch synchronisers; only the second stage is read.
  logic [1:0] sw_meta_q;
  logic [1:0] sw_sync_q;
  // Set being sent to the field.
  logic [sro_pkg::SET_W-1:0] cur_set_q;
  // Sequencer state, phase counter and current channel.
  sro_pkg::sro_state_t state_q;
  sro_pkg::sro_state_t state_d;
  logic [sro_pkg::CNT_W-1:0] cnt_q;
  logic [sro_pkg::CNT_W-1:0] cnt_d;
  logic [1:0] chan_q;
  logic [1:0] chan_d;
  // Registered outputs and their next values.
  logic [sro_pkg::WORD_W-1:0] data_d;
  logic [sro_pkg::NUM_CHAN-1:0] strobe_d;
  logic range_err_d;
  // Polarity that the strobe lines were last driven with.
  logic pol_q;
  // FIFO handshake.
  logic fifo_valid;
  logic [sro_pkg::SET_W-1:0] fifo_data;

  // Synchronised switches.
  wire sw_bcd_w = sw_sync_q[0];
  wire sw_pol_w = sw_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Format helpers.
  ////////////////////////////////////////////////////////////////////////////

  // Converts a binary word to five decimal digits by shift and add-three.
  function automatic logic [19:0] bin_to_bcd(input logic [15:0] bin);
    logic [35:0] acc;
    acc = {20'h0_0000, bin};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 5; d++) begin
        if (acc[16 + 4*d +: 4] > 4'h4) begin
          acc[16 + 4*d +: 4] = acc[16 + 4*d +: 4] + 4'h3;
        end
      end
      acc = {acc[34:0], 1'b0};
    end
    return acc[35:16];
  endfunction

  // True when any nibble of the word is not a decimal digit.
  function automatic logic bad_digit(input logic [15:0] w);
    logic bad;
    bad = 1'b0;
    for (int d = 0; d < 4; d++) begin
      if (w[4*d +: 4] > sro_pkg::DIGIT_MAX) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction

  // Word of the selected channel from the set being sent.
  function automatic logic [15:0] pick(input logic [sro_pkg::SET_W-1:0] s,
                                       input logic [1:0] c);
    return s[sro_pkg::CHAN_ONE_LSB + sro_pkg::WORD_W*c +: sro_pkg::WORD_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Backplane capture.
  ////////////////////////////////////////////////////////////////////////////

  // Word mapping replaces all four words; bit mapping touches masked bits only.
  assign hold_d = word_mapped_in ? bus_words_in
                : (hold_q & ~bus_bit_mask_in) | (bus_words_in & bus_bit_mask_in);

  // A write lands in the holding words only when the buffer can take the set.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_q <= '0;
    end else if (bus_write_in && bus_ready_out) begin
      hold_q <= hold_d;
    end
  end

  // The complete set is queued so the field side paces itself.
  sro_fifo #(
    .WIDTH(sro_pkg::SET_W),
    .DEPTH(sro_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .in_data_in(hold_d),
    .in_valid_in(bus_write_in),
    .in_ready_out(bus_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(state_q == sro_pkg::SRO_IDLE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Switch synchronisers and format status.
  ////////////////////////////////////////////////////////////////////////////

  // Toggle switches are asynchronous pins and pass two flops first.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_meta_q <= '0;
      sw_sync_q <= '0;
      fmt_bcd_out <= 1'b0;
      fmt_error_out <= 1'b0;
    end else begin
      sw_meta_q <= {strobe_polarity_switch_in, format_bcd_switch_in};
      sw_sync_q <= sw_meta_q;
      fmt_bcd_out <= sw_bcd_w || map_bcd_in;
      fmt_error_out <= sw_bcd_w && map_bcd_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field sequencer.
  ////////////////////////////////////////////////////////////////////////////

  // Formatted word for the channel about to be driven.
  wire [1:0] next_chan_w = (state_q == sro_pkg::SRO_IDLE) ? 2'd0 : chan_q + 2'd1;
  wire [15:0] raw_w = (state_q == sro_pkg::SRO_IDLE) ? pick(fifo_data, 2'd0)
                                                      : pick(cur_set_q, next_chan_w);
  wire [19:0] conv_w = bin_to_bcd(raw_w);
  // The switch in decimal position converts; binary position passes the word.
  wire [15:0] fmt_w = sw_bcd_w ? conv_w[15:0] : raw_w;
  wire fmt_range_w = sw_bcd_w ? (raw_w > sro_pkg::BCD_MAX)
                   : (map_bcd_in && bad_digit(raw_w));
  wire cnt_zero_w = (cnt_q == '0);
  // Active strobe level follows the polarity switch for every line.
  wire [3:0] strobe_idle_w = {4{~sw_pol_w}};

  // Each channel runs set-up, strobe and hold; channels go one to four.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    chan_d = chan_q;
    data_d = data_out;
    range_err_d = range_error_out;
    strobe_d = strobe_idle_w;
    case (state_q)
      sro_pkg::SRO_IDLE: begin
        if (fifo_valid) begin
          chan_d = 2'd0;
          data_d = fmt_w;
          range_err_d = fmt_range_w;
          cnt_d = sro_pkg::CNT_W'(sro_pkg::SETUP_CYC - 1);
          state_d = sro_pkg::SRO_SETUP;
        end
      end
      sro_pkg::SRO_SETUP: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_zero_w) begin
          cnt_d = sro_pkg::CNT_W'(STROBE_CYC - 1);
          state_d = sro_pkg::SRO_STROBE;
          strobe_d = strobe_idle_w ^ (4'b0001 << chan_q);
        end
      end
      sro_pkg::SRO_STROBE: begin
        cnt_d = cnt_q - 1'b1;
        strobe_d = strobe_idle_w ^ (4'b0001 << chan_q);
        if (cnt_zero_w) begin
          strobe_d = strobe_idle_w;
          cnt_d = sro_pkg::CNT_W'(sro_pkg::HOLD_CYC - 1);
          state_d = sro_pkg::SRO_HOLD;
        end
      end
      sro_pkg::SRO_HOLD: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_zero_w) begin
          if (chan_q == 2'd3) begin
            state_d = sro_pkg::SRO_IDLE;
          end else begin
            chan_d = next_chan_w;
            data_d = fmt_w;
            range_err_d = fmt_range_w;
            cnt_d = sro_pkg::CNT_W'(sro_pkg::SETUP_CYC - 1);
            state_d = sro_pkg::SRO_SETUP;
          end
        end
      end
      default: begin
        state_d = sro_pkg::SRO_IDLE;
      end
    endcase
  end

  // Sequencer registers; data lines feed all devices in parallel.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= sro_pkg::SRO_IDLE;
      cnt_q <= '0;
      chan_q <= '0;
      cur_set_q <= '0;
      data_out <= '0;
      strobe_out <= '1;
      pol_q <= 1'b0;
      busy_out <= 1'b0;
      range_error_out <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      if (state_q == sro_pkg::SRO_IDLE && fifo_valid) begin
        cur_set_q <= fifo_data;
      end
      data_out <= data_d;
      strobe_out <= strobe_d;
      pol_q <= sw_pol_w;
      busy_out <= (state_d != sro_pkg::SRO_IDLE);
      range_error_out <= range_err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and their helper counters.
  ////////////////////////////////////////////////////////////////////////////

  // Length of the strobe now running and time since the sequencer left idle.
  logic [sro_pkg::CNT_W:0] width_q;
  logic [31:0] busy_cnt_q;
  // Active mask is taken against the polarity the lines were driven with.
  // Using the live switch instead would show all four lines active for one
  // cycle whenever the polarity switch flips.
  wire [3:0] strobe_act_w = strobe_out ^ {4{~pol_q}};
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      width_q <= '0;
      busy_cnt_q <= '0;
    end else begin
      width_q <= (strobe_act_w != '0) ? width_q + 1'b1 : '0;
      busy_cnt_q <= busy_out ? busy_cnt_q + 1'b1 : '0;
    end
  end

  strobe_onehot_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $onehot0(strobe_act_w))
    else $error("more than one strobe active");

  strobe_width_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(strobe_act_w) != '0 && strobe_act_w == '0 && $stable(sw_pol_w)
      |-> width_q == (sro_pkg::CNT_W + 1)'(STROBE_CYC))
    else $error("strobe width wrong");

  data_stable_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state_q inside {sro_pkg::SRO_STROBE, sro_pkg::SRO_HOLD} |-> $stable(data_out))
    else $error("data moved around strobe");

  idle_level_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state_q == sro_pkg::SRO_IDLE && $stable(sw_pol_w) ##1 $stable(sw_pol_w)
      |-> strobe_out == {4{~sw_pol_w}})
    else $error("idle strobe level wrong");

  word_capture_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    bus_write_in && bus_ready_out && word_mapped_in |=> hold_q == $past(bus_words_in))
    else $error("four words not captured together");

  bit_mask_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    bus_write_in && !word_mapped_in
      |=> (hold_q & ~$past(bus_bit_mask_in)) == ($past(hold_q) & ~$past(bus_bit_mask_in)))
    else $error("unmasked bit changed");

  chan_order_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state_q == sro_pkg::SRO_HOLD && cnt_zero_w && chan_q != 2'd3
      |=> chan_q == $past(chan_q) + 2'd1 && state_q == sro_pkg::SRO_SETUP)
    else $error("channels out of order");

  response_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    busy_out |-> busy_cnt_q < 32'(RESPONSE_CYC))
    else $error("field update too slow");

  format_err_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ##1 fmt_error_out == $past(sw_bcd_w && map_bcd_in))
    else $error("format error flag wrong");

  strobe_data_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state_q == sro_pkg::SRO_STROBE && !sw_bcd_w && $stable(sw_bcd_w)
      && $past(state_q) == sro_pkg::SRO_SETUP
      |-> data_out == pick(cur_set_q, chan_q))
    else $error("wrong channel word driven");

endmodule

// ---- verif/sro_field_model.sv ----
// Model of the latching field devices that share the strobed data lines.
`timescale 1ns/10ps
module sro_field_model (
  input wire logic sys_clk_in,
  input wire logic [15:0] data_in,
  input wire logic [3:0] strobe_in,
  input wire logic polarity_high_in,
  output logic [63:0] latched_out
);
  // Strobe lines seen in active-high sense.
  wire [3:0] act = polarity_high_in ? strobe_in : ~strobe_in;
  // Strobe levels of the previous cycle.
  logic [3:0] act_q;

  initial begin
    act_q = 4'h0;
    latched_out = 64'h0000_0000_0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The devices only read the lines and never drive them, so none contends.
  // Each device takes all 16 lines as its own strobe ends, ignoring the rest.
  always @(posedge sys_clk_in) begin
    act_q <= act;
    for (int i = 0; i < 4; i++) begin
      if (act_q[i] && !act[i]) begin
        latched_out[i*16 +: 16] <= data_in;
      end
    end
  end
endmodule

// ---- verif/sro_port_test.sv ----
// Self-checking bench for the strobed four-channel output port.
`timescale 1ns/10ps
module sro_port_test;
  // Short strobe keeps the run brief; all timing expectations derive from it.
  localparam int STB = 8;
  localparam int SET_CYC = 4 * (sro_pkg::SETUP_CYC + STB + sro_pkg::HOLD_CYC);
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic bus_write_in = 1'b0;
  logic [63:0] bus_words_in = 64'h0000_0000_0000_0000;
  logic [63:0] bus_bit_mask_in = 64'h0000_0000_0000_0000;
  logic word_mapped_in = 1'b1;
  logic map_bcd_in = 1'b0;
  logic fmt_sw = 1'b0;
  logic pol_sw = 1'b0;
  logic bus_ready_out, busy_out, fmt_bcd_out, fmt_error_out, range_error_out;
  logic [15:0] data_out;
  logic [3:0] strobe_out;
  logic [63:0] latched;
  logic mon_en = 1'b0;
  int miscompares = 0;
  int compares = 0;

  always #4 sys_clk_in = ~sys_clk_in;

  sro_port #(.STROBE_CYC(STB), .RESPONSE_CYC(SET_CYC + 8)) dut (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .bus_write_in(bus_write_in), .bus_words_in(bus_words_in),
    .bus_bit_mask_in(bus_bit_mask_in), .word_mapped_in(word_mapped_in),
    .map_bcd_in(map_bcd_in), .format_bcd_switch_in(fmt_sw),
    .strobe_polarity_switch_in(pol_sw), .bus_ready_out(bus_ready_out),
    .data_out(data_out), .strobe_out(strobe_out), .busy_out(busy_out),
    .fmt_bcd_out(fmt_bcd_out), .fmt_error_out(fmt_error_out),
    .range_error_out(range_error_out));

  sro_field_model field (.sys_clk_in(sys_clk_in), .data_in(data_out),
    .strobe_in(strobe_out), .polarity_high_in(pol_sw), .latched_out(latched));

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares a value up to 64 bits wide.
  task automatic chk_v(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compares a one-bit flag.
  task automatic chk_b(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Presents one write and returns the ready level seen at its sampling edge.
  task automatic wr(input logic [63:0] w, input logic [63:0] m, input logic wm,
                    output logic acc);
    @(posedge sys_clk_in);
    bus_write_in <= 1'b1;
    bus_words_in <= w;
    bus_bit_mask_in <= m;
    word_mapped_in <= wm;
    @(negedge sys_clk_in);
    acc = bus_ready_out;
  endtask

  // Drops the write strobe at the sampling edge of the last write.
  task automatic wr_end();
    @(posedge sys_clk_in);
    bus_write_in <= 1'b0;
  endtask

  // Holds a write until it is taken, within a bounded wait.
  task automatic put(input logic [63:0] w, input logic [63:0] m, input logic wm);
    logic acc;
    int n;
    acc = 1'b0;
    for (n = 0; n < 50 && acc !== 1'b1; n++) begin
      wr(w, m, wm, acc);
    end
    wr_end();
    if (acc !== 1'b1) begin
      chk_b("bus_ready_out", 1'b1, acc);
      report_and_stop();
    end
  endtask

  // Waits until busy has stayed low for ten cycles; returns cycles waited before those ten.
  task automatic wait_idle(output int cyc);
    int low;
    low = 0;
    cyc = 0;
    while (low < 10 && cyc < 20000) begin
      @(negedge sys_clk_in);
      cyc++;
      low = (busy_out === 1'b1) ? 0 : low + 1;
    end
    if (low < 10) begin
      chk_v("busy_out low cycles", 64'hA, low);
      report_and_stop();
    end
    cyc = cyc - 10;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watches the field lines: one strobe at a time, in order, fixed width, data held.
  logic [3:0] act, act_p;
  logic [15:0] dat_p;
  int wid, nxt;
  always @(negedge sys_clk_in) begin
    act = pol_sw ? strobe_out : ~strobe_out;
    if (!mon_en) begin
      act_p = 4'h0;
      wid = 0;
      nxt = 0;
    end else begin
      if (act != 4'h0 && act_p != 4'h0) chk_v("data during strobe", dat_p, data_out);
      if ($countones(act) > 1) chk_v("active strobes", 64'h1, $countones(act));
      if (act != 4'h0 && act_p == 4'h0) begin
        chk_v("strobe order", 64'h1 << nxt, act);
        nxt = (nxt + 1) % 4;
      end
      if (act == 4'h0 && act_p != 4'h0) chk_v("strobe width", STB, wid);
      wid = (act != 4'h0) ? wid + 1 : 0;
      act_p = act;
      dat_p = data_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  logic [63:0] exp_set, last;
  logic acc;
  int cyc, n;
  initial begin
    repeat (8) @(posedge sys_clk_in);
    chk_v("strobe_out in reset", 64'hF, strobe_out);
    chk_v("data_out in reset", 64'h0, data_out);
    chk_b("bus_ready_out in reset", 1'b1, bus_ready_out);
    rst_in <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    mon_en <= 1'b1;
    chk_v("idle strobes low sense", 64'hF, strobe_out);
    $display("test reset done");
    // Full-range binary words, captured in one write and strobed out in order.
    exp_set = 64'hFFFF_8001_1234_0000;
    put(exp_set, 64'h0, 1'b1);
    wait_idle(cyc);
    chk_v("latched words", exp_set, latched);
    chk_b("response in time", 1'b1, cyc <= SET_CYC + 4);
    chk_b("range_error_out binary", 1'b0, range_error_out);
    $display("test binary done");
    // Bit-mapped write changes only the masked bits.
    put(64'hAAAA_5555_AAAA_5555, 64'h0000_FFFF_0000_00FF, 1'b0);
    wait_idle(cyc);
    exp_set = (exp_set & ~64'h0000_FFFF_0000_00FF) | (64'hAAAA_5555_AAAA_5555 & 64'h0000_FFFF_0000_00FF);
    chk_v("bit-mapped words", exp_set, latched);
    $display("test bitmap done");
    // Every mapping type and switch combination.
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_in);
      map_bcd_in <= i[0];
      fmt_sw <= i[1];
      repeat (5) @(negedge sys_clk_in);
      chk_b("fmt_bcd_out", i[0] | i[1], fmt_bcd_out);
      chk_b("fmt_error_out", i[0] & i[1], fmt_error_out);
    end
    $display("test format table done");
    // Decimal switch with binary mapping turns words into four digits.
    // Channel four holds a value above four digits and raises the range flag.
    @(posedge sys_clk_in);
    map_bcd_in <= 1'b0;
    put(64'h2710_270F_0000_04D2, 64'h0, 1'b1);
    wait_idle(cyc);
    chk_v("decimal words", 64'h0000_9999_0000_1234, latched);
    chk_b("range_error_out decimal", 1'b1, range_error_out);
    $display("test decimal done");
    // Second reset with strobes switched to active high.
    @(posedge sys_clk_in);
    mon_en <= 1'b0;
    rst_in <= 1'b1;
    pol_sw <= 1'b1;
    fmt_sw <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    mon_en <= 1'b1;
    chk_v("idle strobes high sense", 64'h0, strobe_out);
    // Fill the buffer until refused, then drain it.
    acc = 1'b1;
    for (n = 0; n < 8 && acc === 1'b1; n++) begin
      wr(64'h1111_2222_3333_4444 + n, 64'h0, 1'b1, acc);
      if (acc === 1'b1) last = 64'h1111_2222_3333_4444 + n;
    end
    wr_end();
    chk_b("sets taken before full", 1'b1, n >= 5 && n <= 6);
    wait_idle(cyc);
    chk_v("drained words", last, latched);
    $display("test buffer done");
    report_and_stop();
  end
endmodule
